// file: rtl/msdu_cfg.svh
// register map, field positions, reset values and timing counts of the monitor sequencer
`ifndef MSDU_CFG_SVH
`define MSDU_CFG_SVH
`define MSDU_ADDR_CODE_FIRST 8'h10
`define MSDU_ADDR_CODE_LAST 8'h17
`define MSDU_ADDR_CTRL_ONE 8'h18
`define MSDU_ADDR_CTRL_TWO 8'h19
`define MSDU_ADDR_CTRL_THREE 8'h1A
`define MSDU_ADDR_OUT_CFG 8'h1B
`define MSDU_ADDR_UPD_CTRL 8'h1C
`define MSDU_ADDR_STATUS 8'h1D
// control one fields
`define MSDU_C1_RUN 0
`define MSDU_C1_SEL_LO 1
`define MSDU_C1_SEL_HI 2
`define MSDU_C1_PWRDN 6
// control two fields
`define MSDU_C2_CHAN_LO 0
`define MSDU_C2_CHAN_HI 2
`define MSDU_C2_SINGLE 4
`define MSDU_C2_NOAVG 5
// control three fields
`define MSDU_C3_FAST 0
`define MSDU_C3_SWLOAD 3
`define MSDU_C3_VDDREF 4
// output configuration fields
`define MSDU_OC_GAIN_HI 3
`define MSDU_OC_LD_LO 4
`define MSDU_OC_LD_HI 5
// update control fields
`define MSDU_UC_LOAD 0
`define MSDU_UC_INTREF 4
// reset values
`define MSDU_RST_CTRL 8'h00
`define MSDU_RST_OUT_CFG 8'h00
`define MSDU_RST_UPD_CTRL 8'h00
`define MSDU_RST_CODE 8'h00
// conversion timing
`define MSDU_CLK_HZ 50000000
`define MSDU_SLOW_HZ 1400
`define MSDU_FAST_HZ 22000
`define MSDU_SLOW_DIV (`MSDU_CLK_HZ / `MSDU_SLOW_HZ)
`define MSDU_FAST_DIV (`MSDU_CLK_HZ / `MSDU_FAST_HZ)
`define MSDU_CAL_MS 5
`define MSDU_CAL_CYCLES (`MSDU_CLK_HZ / 1000 * `MSDU_CAL_MS)
`define MSDU_AVG_COUNT 16
`define MSDU_ADC_CLKS 16
`endif

// file: rtl/msdu_pkg.sv
// types shared by the monitor sequencer files
package msdu_pkg;
   typedef enum logic [2:0] {
      MSDU_CH_SUPPLY = 3'h0,
      MSDU_CH_LOCAL = 3'h1,
      MSDU_CH_REMOTE = 3'h2,
      MSDU_CH_IN_THREE = 3'h3,
      MSDU_CH_IN_FOUR = 3'h4
   } msdu_chan_e;
   typedef enum logic [1:0] {
      MSDU_ST_CAL = 2'h0,
      MSDU_ST_IDLE = 2'h1,
      MSDU_ST_CONV = 2'h2
   } msdu_state_e;
   typedef logic [11:0] msdu_code_t;
endpackage

// file: rtl/msdu_rate_div.sv
// conversion clock divider: one-cycle tick at the slow or fast conversion rate
`timescale 1ns/1ps
`default_nettype none
`include "msdu_cfg.svh"
module msdu_rate_div
   import msdu_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // control
   input wire logic run,
   input wire logic fast,
   // tick out
   output logic tick
);
   localparam int unsigned SLOW_N = `MSDU_SLOW_DIV;
   localparam int unsigned FAST_N = `MSDU_FAST_DIV;
   logic [15:0] cnt;
   logic [15:0] limit;

   assign limit = fast ? 16'(FAST_N - 1) : 16'(SLOW_N - 1);

   // rate switch applies at once to the running count; a count past the new limit restarts at zero with a tick, so no long wait
   always_ff @(posedge mclk) begin
      if (sys_rst || !run) begin
         cnt <= 16'h0000;
         tick <= 1'b0;
      end else if (cnt >= limit) begin
         cnt <= 16'h0000;
         tick <= 1'b1;
      end else begin
         cnt <= cnt + 16'h0001;
         tick <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// file: rtl/msdu_top.sv
// monitor sequencer and double-buffered output code registers
// Functional notes
// RULE1: after calibration, idle with no conversions and all outputs at zero
// RULE2: control one bit 0 set starts cyclic monitoring
// RULE3: cyclic order supply, local, remote or inputs one-two, three, four, repeat
// RULE4: cycle repeats until control one bit 0 cleared
// RULE5: control two bit 4 selects single-channel mode
// RULE6: averaging on after reset, sixteen conversions per result
// RULE7: control two bit 5 disables averaging
// RULE8: control one bits 1 and 2 choose inputs or remote diode
// RULE9: control three bit 4 picks internal or supply reference
// RULE10: four codes written as high and low bytes at 0x10 to 0x17
// RULE11: falling edge on update pin loads pending codes by default
// RULE12: control three bit 3 hands update control to registers
// RULE13: code read returns live output until an update happens
// RULE14: output configuration bits 4 and 5 issue a register update
// RULE15: pin must rise and fall again before another pin load
// RULE16: serial port starts two-wire; four-wire locks until power cycle
// RULE17: control three bit 0 selects fast conversion clock, filters off
// RULE18: host waits about 5 ms after supply before communicating
// RULE19: after early traffic, host measures supply before temperature
// RULE20: power-down switches all outputs off to high impedance
// RULE21: output configuration bits 0 to 3 set gain two per output
// RULE22: update control selects output reference, external after reset
// RULE23: update pin synchronised, one load pulse per falling edge
`timescale 1ns/1ps
`default_nettype none
`include "msdu_cfg.svh"
module msdu_top
   import msdu_pkg::*;
#(
   parameter int unsigned CAL_CYCLES = `MSDU_CAL_CYCLES
) (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // register port from the serial front end
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // serial mode selection from the front end
   input wire logic four_wire_sel,
   output logic four_wire_locked,
   // output update pin
   input wire logic output_load_strobe_n,
   // converter side
   output logic conv_start,
   output logic [2:0] conv_chan,
   output logic remote_diode_sel,
   output logic adc_ref_vdd,
   output logic adc_fast,
   output logic diode_filter_on,
   output logic calibrating,
   // analog output side
   output logic [47:0] out_codes,
   output logic [3:0] out_gain_two,
   output logic out_ref_internal,
   output logic out_hiz
);
   ////////////////////////////////////////////////////////////////
   // registers
   logic [7:0] ctrl_one;
   logic [7:0] ctrl_two;
   logic [7:0] ctrl_three;
   logic [7:0] out_cfg;
   logic [7:0] upd_ctrl;
   logic [7:0] pend [8];
   logic [7:0] live [8];
   logic load_pulse;
   logic pin_meta;
   logic pin_sync;
   logic pin_prev;
   logic sw_load;
   msdu_state_e state;
   msdu_chan_e chan;
   logic [31:0] cal_cnt;
   logic [4:0] avg_cnt;
   logic [4:0] adc_cnt;
   logic tick;

   function automatic logic is_code(input logic [7:0] a);
      return (a >= `MSDU_ADDR_CODE_FIRST) && (a <= `MSDU_ADDR_CODE_LAST);
   endfunction

   function automatic logic wr_hit(input logic [7:0] a);
      return reg_wr && (reg_addr == a);
   endfunction

   ////////////////////////////////////////////////////////////////
   // control registers
   // RULE2 RULE4 run bit
   // RULE8 RULE20 input select, power-down
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ctrl_one <= `MSDU_RST_CTRL;
      end else if (wr_hit(`MSDU_ADDR_CTRL_ONE)) begin
         ctrl_one <= reg_wdata;
      end
   end

   // RULE5 RULE6 RULE7 reset clears both, so averaging is on
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ctrl_two <= `MSDU_RST_CTRL;
      end else if (wr_hit(`MSDU_ADDR_CTRL_TWO)) begin
         ctrl_two <= reg_wdata;
      end
   end

   // RULE17 slow speed after reset
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ctrl_three <= `MSDU_RST_CTRL;
      end else if (wr_hit(`MSDU_ADDR_CTRL_THREE)) begin
         ctrl_three <= reg_wdata;
      end
   end

   // load bits self-clear so a later write must set them again
   // RULE21 gain bits kept, load bits strobe
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         out_cfg <= `MSDU_RST_OUT_CFG;
      end else if (wr_hit(`MSDU_ADDR_OUT_CFG)) begin
         out_cfg <= reg_wdata;
      end else begin
         out_cfg[`MSDU_OC_LD_HI:`MSDU_OC_LD_LO] <= 2'h0;
      end
   end

   // RULE22 external reference after reset
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         upd_ctrl <= `MSDU_RST_UPD_CTRL;
      end else if (wr_hit(`MSDU_ADDR_UPD_CTRL)) begin
         upd_ctrl <= reg_wdata;
      end else begin
         upd_ctrl[`MSDU_UC_LOAD] <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // serial mode lock
   // RULE16 only four-wire ever locks; only reset clears it
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         four_wire_locked <= 1'b0;
      end else if (four_wire_sel) begin
         four_wire_locked <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////
   // update pin and load command
   // asynchronous pin; flops reset to its idle high so no false fall
   // RULE23 two-stage synchroniser then edge detect
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pin_meta <= 1'b1;
         pin_sync <= 1'b1;
         pin_prev <= 1'b1;
      end else begin
         pin_meta <= output_load_strobe_n;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   // register load fires when bits 4 and 5 are both written as one
   // RULE14 RULE12 register path only with control three bit 3
   assign sw_load = ctrl_three[`MSDU_C3_SWLOAD]
      && ((out_cfg[`MSDU_OC_LD_HI:`MSDU_OC_LD_LO] == 2'h3) || upd_ctrl[`MSDU_UC_LOAD]);

   // sources are exclusive, so a pin fall cannot double a register load
   // RULE11 RULE15 one pulse per fall; a new fall needs a rise first
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         load_pulse <= 1'b0;
      end else begin
         load_pulse <= ctrl_three[`MSDU_C3_SWLOAD] ? sw_load : (pin_prev && !pin_sync);
      end
   end

   ////////////////////////////////////////////////////////////////
   // code storage
   // RULE10 byte-wise writes into holding registers
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         for (int i = 0; i < 8; i++) begin
            pend[i] <= `MSDU_RST_CODE;
         end
      end else if (reg_wr && is_code(reg_addr)) begin
         pend[reg_addr[2:0]] <= reg_wdata;
      end
   end

   // RULE1 outputs at zero until a load
   // RULE23 all four codes move together
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         for (int i = 0; i < 8; i++) begin
            live[i] <= `MSDU_RST_CODE;
         end
      end else if (load_pulse) begin
         for (int i = 0; i < 8; i++) begin
            live[i] <= pend[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // read back
   // RULE13 reads show live codes, never the holding ones
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         if (is_code(reg_addr)) begin
            reg_rdata <= live[reg_addr[2:0]];
         end else begin
            case (reg_addr)
               `MSDU_ADDR_CTRL_ONE: reg_rdata <= ctrl_one;
               `MSDU_ADDR_CTRL_TWO: reg_rdata <= ctrl_two;
               `MSDU_ADDR_CTRL_THREE: reg_rdata <= ctrl_three;
               `MSDU_ADDR_OUT_CFG: reg_rdata <= out_cfg;
               `MSDU_ADDR_UPD_CTRL: reg_rdata <= upd_ctrl;
               // status is read only; writes to it fall to nothing
               `MSDU_ADDR_STATUS: reg_rdata <= {2'h0, four_wire_locked, state, chan};
               default: reg_rdata <= 8'h00;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // sequencer
   msdu_rate_div u_div (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .run(state == MSDU_ST_CONV),
      .fast(ctrl_three[`MSDU_C3_FAST]),
      .tick(tick)
   );

   function automatic msdu_chan_e next_chan(input msdu_chan_e c);
      case (c)
         MSDU_CH_SUPPLY: return MSDU_CH_LOCAL;
         MSDU_CH_LOCAL: return MSDU_CH_REMOTE;
         MSDU_CH_REMOTE: return MSDU_CH_IN_THREE;
         MSDU_CH_IN_THREE: return MSDU_CH_IN_FOUR;
         default: return MSDU_CH_SUPPLY;
      endcase
   endfunction

   // single mode pins the channel; otherwise the cyclic choice passes through
   function automatic msdu_chan_e pick_chan(input msdu_chan_e c);
      if (ctrl_two[`MSDU_C2_SINGLE]) begin
         return msdu_chan_e'(ctrl_two[`MSDU_C2_CHAN_HI:`MSDU_C2_CHAN_LO]);
      end
      return c;
   endfunction

   // traffic during calibration is not blocked; only the sequencer waits
   // RULE1 calibration then idle
   // RULE2 RULE4 run bit enters and leaves conversion
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state <= MSDU_ST_CAL;
         cal_cnt <= 32'h0;
      end else begin
         case (state)
            MSDU_ST_CAL: begin
               if (cal_cnt >= 32'(CAL_CYCLES - 1)) begin
                  state <= MSDU_ST_IDLE;
               end
               cal_cnt <= cal_cnt + 32'h1;
            end
            MSDU_ST_IDLE: begin
               if (ctrl_one[`MSDU_C1_RUN]) begin
                  state <= MSDU_ST_CONV;
               end
            end
            MSDU_ST_CONV: begin
               if (!ctrl_one[`MSDU_C1_RUN]) begin
                  state <= MSDU_ST_IDLE;
               end
            end
            default: state <= MSDU_ST_IDLE;
         endcase
      end
   end

   // leaving conversion rewinds the channel so a cyclic restart begins at supply, a single-mode one at the selected channel
   // one conversion is a fixed number of conversion clocks
   // RULE6 RULE7 sixteen conversions per result unless disabled
   // RULE3 RULE5 cyclic stepping or fixed single channel
   always_ff @(posedge mclk) begin
      if (sys_rst || state != MSDU_ST_CONV) begin
         adc_cnt <= 5'h0;
         avg_cnt <= 5'h0;
         conv_start <= 1'b0;
         chan <= pick_chan(MSDU_CH_SUPPLY);
      end else begin
         conv_start <= tick && (adc_cnt == 5'h0);
         if (tick) begin
            if (adc_cnt == 5'(`MSDU_ADC_CLKS - 1)) begin
               adc_cnt <= 5'h0;
               if (ctrl_two[`MSDU_C2_NOAVG] || avg_cnt == 5'(`MSDU_AVG_COUNT - 1)) begin
                  avg_cnt <= 5'h0;
                  chan <= pick_chan(next_chan(chan));
               end else begin
                  avg_cnt <= avg_cnt + 5'h1;
               end
            end else begin
               adc_cnt <= adc_cnt + 5'h1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // outputs
   assign conv_chan = chan;
   // RULE8 both select bits clear means remote diode
   assign remote_diode_sel = (ctrl_one[`MSDU_C1_SEL_HI:`MSDU_C1_SEL_LO] == 2'h0);
   // RULE9 reference for input channels
   assign adc_ref_vdd = ctrl_three[`MSDU_C3_VDDREF];
   // RULE17 filters off at fast speed
   assign adc_fast = ctrl_three[`MSDU_C3_FAST];
   assign diode_filter_on = !ctrl_three[`MSDU_C3_FAST];
   assign calibrating = (state == MSDU_ST_CAL);
   // each code is its high byte over the top nibble of its low byte
   assign out_codes = {live[7], live[6][7:4], live[5], live[4][7:4],
                       live[3], live[2][7:4], live[1], live[0][7:4]};
   // RULE21 per-output gain
   assign out_gain_two = out_cfg[`MSDU_OC_GAIN_HI:0];
   // RULE22 reference select
   assign out_ref_internal = upd_ctrl[`MSDU_UC_INTREF];
   // RULE20 power-down floats all outputs
   assign out_hiz = ctrl_one[`MSDU_C1_PWRDN];
endmodule
`default_nettype wire

// file: tb/msdu_top_sva.sv
// port assertions for the monitor sequencer
`timescale 1ns/1ps
`default_nettype none
module msdu_top_sva #(
   parameter int unsigned CAL_CYCLES = 20
) (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // register port
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   // pins and levels
   input wire logic four_wire_locked,
   input wire logic output_load_strobe_n,
   input wire logic conv_start,
   input wire logic calibrating,
   input wire logic remote_diode_sel,
   input wire logic adc_ref_vdd,
   input wire logic adc_fast,
   input wire logic [47:0] out_codes,
   input wire logic [3:0] out_gain_two,
   input wire logic out_ref_internal
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);
   logic pin_q;
   // pin seen one edge later to spot its fall
   always_ff @(posedge mclk) begin
      pin_q <= output_load_strobe_n;
   end
   wire logic fall_evt = pin_q & ~output_load_strobe_n;
   wire logic wr_one = reg_wr && reg_addr == 8'h18;
   ////////////////////////////////////////
   AST_CAL_IDLE: assert property (calibrating |-> !conv_start)
      else $error("conversion while calibrating");
   AST_STOP: assert property (wr_one && !reg_wdata[0] |-> ##3 (!conv_start) [*8])
      else $error("conversion after stop");
   AST_DIODE: assert property (wr_one |=> remote_diode_sel == ($past(reg_wdata[2:1]) == 2'h0))
      else $error("input pair select wrong");
   AST_ADC: assert property (reg_wr && reg_addr == 8'h1A |=>
      adc_fast == $past(reg_wdata[0]) && adc_ref_vdd == $past(reg_wdata[4]))
      else $error("converter setup wrong");
   AST_GAIN: assert property (reg_wr && reg_addr == 8'h1B |=> out_gain_two == $past(reg_wdata[3:0]))
      else $error("gain wrong");
   AST_REF: assert property (reg_wr && reg_addr == 8'h1C |=> out_ref_internal == $past(reg_wdata[4]))
      else $error("output reference wrong");
   AST_LOAD: assert property ($changed(out_codes) |->
      $past(fall_evt, 4) || $past(fall_evt, 5) || $past(fall_evt, 6) || $past(reg_wr, 3))
      else $error("codes changed without a load");
   AST_LOCK: assert property (four_wire_locked |=> four_wire_locked)
      else $error("lock released");
   cover property (fall_evt);
   cover property (conv_start);
   cover property ($rose(four_wire_locked));
endmodule
bind msdu_top msdu_top_sva #(.CAL_CYCLES(CAL_CYCLES)) u_msdu_top_sva (.*);
`default_nettype wire

// file: tb/msdu_host_model.sv
// host model driving the register port and update pin
`timescale 1ns/1ps
`default_nettype none
module msdu_host_model (
   // clock
   input wire logic mclk,
   // register port
   output logic reg_wr = 1'b0,
   output logic reg_rd = 1'b0,
   output logic [7:0] reg_addr = 8'h00,
   output logic [7:0] reg_wdata = 8'h00,
   input wire logic [7:0] reg_rdata,
   // update pin
   output logic output_load_strobe_n = 1'b1
);
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      // released lines never show stale data
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1;
      d = reg_rdata;
   endtask
   task automatic ld();
      @(posedge mclk);
      output_load_strobe_n <= 1'b0;
      repeat (3) @(posedge mclk);
      output_load_strobe_n <= 1'b1;
      repeat (3) @(posedge mclk);
   endtask
endmodule
`default_nettype wire

// file: tb/msdu_top_tb.sv
// self-checking bench for the monitor sequencer
`timescale 1ns/1ps
`default_nettype none
module msdu_top_tb;
   localparam int unsigned CAL_CYCLES = 20;
   logic mclk, sys_rst, reg_wr, reg_rd, four_wire_sel, four_wire_locked;
   logic output_load_strobe_n, conv_start, remote_diode_sel, adc_ref_vdd;
   logic adc_fast, diode_filter_on, calibrating, out_ref_internal, out_hiz;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [2:0] conv_chan;
   logic [3:0] out_gain_two;
   logic [47:0] out_codes, cur, nxt;
   int n_fail = 0;
   int num_checks = 0;
   int seed = 66;
   int hits;
   msdu_top #(.CAL_CYCLES(CAL_CYCLES)) u_msdu_top (.*);
   msdu_host_model u_msdu_host_model (.*);
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   ////////////////////////////////////////
   task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic w(input logic [7:0] a, input logic [7:0] d);
      u_msdu_host_model.wr(a, d);
   endtask
   task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      u_msdu_host_model.rd(a, d);
      chk($sformatf("reg %h", a), 48'(e), 48'(d));
   endtask
   function automatic logic [7:0] hi(input logic [47:0] v, input int i);
      return v[12 * i + 4 +: 8];
   endfunction
   function automatic logic [47:0] rnd();
      return {$random(seed), 16'($random(seed))};
   endfunction
   task automatic put(input logic [47:0] v);
      for (int i = 0; i < 4; i++) begin
         w(8'h10 + 8'(2 * i), {v[12 * i +: 4], 4'h0});
         w(8'h11 + 8'(2 * i), hi(v, i));
      end
   endtask
   // waits for a conversion on a channel other than prev
   task automatic conv(input int lim, input logic [2:0] prev, input logic [2:0] ch);
      int k;
      k = 0;
      do begin
         @(posedge mclk);
         #1;
         k++;
      end while (!(conv_start === 1'b1 && conv_chan !== prev) && k < lim);
      chk("conv_start", 48'h1, 48'(conv_start));
      chk("conv_chan", 48'(ch), 48'(conv_chan));
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // about 80k cycles expected, mostly the three fast-rate conversion waits
   initial begin
      repeat (95000) @(posedge mclk);
      n_fail++;
      close_out();
   end
   ////////////////////////////////////////
   initial begin
      sys_rst = 1'b1;
      four_wire_sel = 1'b0;
      repeat (6) @(posedge mclk);
      sys_rst <= 1'b0;
      repeat (CAL_CYCLES + 4) @(posedge mclk);
      #1;
      chk("calibrating", 48'h0, 48'(calibrating));
      chk("codes", 48'h0, out_codes);
      chk("diode", 48'h1, 48'(remote_diode_sel));
      chk("filter", 48'h1, 48'(diode_filter_on));
      chk("ref", 48'h0, 48'(out_ref_internal));
      for (int a = 8'h18; a < 8'h1D; a++) begin
         chk_reg(8'(a), 8'h00);
      end
      w(8'h30, 8'hA5);
      chk_reg(8'h30, 8'h00);
      $display("reset test done");
      cur = 48'h0;
      repeat (3) begin
         nxt = rnd();
         put(nxt);
         chk_reg(8'h11, hi(cur, 0));
         u_msdu_host_model.ld();
         chk("pin load", nxt, out_codes);
         chk_reg(8'h13, hi(nxt, 1));
         cur = nxt;
      end
      $display("pin test done");
      w(8'h1A, 8'h08);
      nxt = rnd();
      put(nxt);
      u_msdu_host_model.ld();
      chk("pin off", cur, out_codes);
      w(8'h1B, 8'h35);
      repeat (3) @(posedge mclk);
      chk("cfg load", nxt, out_codes);
      chk("gain", 48'h5, 48'(out_gain_two));
      nxt = 48'hFFF000FFF000;
      put(nxt);
      w(8'h1C, 8'h11);
      repeat (3) @(posedge mclk);
      chk("reg load", nxt, out_codes);
      chk("ref", 48'h1, 48'(out_ref_internal));
      $display("register load test done");
      w(8'h1A, 8'h11);
      w(8'h19, 8'h20);
      w(8'h18, 8'h03);
      #1;
      chk("fast", 48'h1, 48'(adc_fast));
      chk("vdd ref", 48'h1, 48'(adc_ref_vdd));
      chk("diode", 48'h0, 48'(remote_diode_sel));
      conv(3000, 3'h7, 3'h0);
      conv(40000, 3'h0, 3'h1);
      w(8'h19, 8'h34);
      conv(40000, 3'h1, 3'h4);
      chk_reg(8'h1D, 8'h14);
      w(8'h18, 8'h00);
      repeat (3) @(posedge mclk);
      chk_reg(8'h1D, 8'h0C);
      hits = 0;
      repeat (3000) begin
         @(posedge mclk);
         #1;
         hits += int'(conv_start !== 1'b0);
      end
      chk("stopped", 48'h0, 48'(hits));
      $display("monitor test done");
      w(8'h18, 8'h40);
      #1;
      chk("hiz", 48'h1, 48'(out_hiz));
      chk("locked", 48'h0, 48'(four_wire_locked));
      @(posedge mclk);
      four_wire_sel <= 1'b1;
      @(posedge mclk);
      four_wire_sel <= 1'b0;
      w(8'h18, 8'h00);
      #1;
      chk("locked", 48'h1, 48'(four_wire_locked));
      chk("hiz", 48'h0, 48'(out_hiz));
      $display("mode test done");
      close_out();
   end
endmodule
`default_nettype wire
